//--- src/dvr_ramp.sv
// digital volume ramp controller with sample stream and register port
`timescale 1ns/1ps
module dvr_ramp
  import dvr_pkg::*;
#(
  parameter int SAMPLE_W   = dvr_pkg::DVR_SAMPLE_W,
  parameter int FIFO_DEPTH = dvr_pkg::DVR_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // mute and fault sources
  input  wire logic                  soft_mute_pin_n,
  input  wire logic                  soft_mute_ctrl,
  input  wire logic                  clock_error,
  input  wire logic                  power_fail,
  // target volumes
  input  wire logic [7:0]            left_target_volume,
  input  wire logic [7:0]            right_target_volume,
  // register port
  input  wire dvr_pkg::dvr_reg_req_type reg_req,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  // sample stream in
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire logic [SAMPLE_W-1:0]   in_data,
  // sample stream out with volume
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic      [SAMPLE_W-1:0]   out_data,
  output dvr_pkg::dvr_vol_type       vol_out,
  output dvr_pkg::dvr_state_type     ramp_state
);

  import dvr_pkg::*;

  typedef struct packed {
    dvr_state_type  state;
    logic [1:0]     src;
    logic [1:0]     cnt;
    dvr_vol_type    vol;
    dvr_normal_type normal;
    dvr_emerg_type  emerg;
    logic [7:0]     rdata;
    logic           rvalid;
  } dvr_ramp_st_type;

  localparam logic [1:0] SRC_UP    = 2'h0;
  localparam logic [1:0] SRC_DOWN  = 2'h1;
  localparam logic [1:0] SRC_EMERG = 2'h2;

  dvr_ramp_st_type st_q;
  dvr_ramp_st_type st_d;

  logic        pin_n_s;
  logic        power_fail_s;
  logic        mute_req;
  logic        emerg_req;
  logic        tick;
  logic [1:0]  sel_src;
  logic [1:0]  sel_iv;
  logic [1:0]  sel_step;
  dvr_vol_type goal;
  logic        at_goal;

  // pin inputs cross from outside the clock domain
  dvr_sync #(
    .W    (2),
    .INIT (2'h1)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({power_fail, soft_mute_pin_n}),
    .sync_out ({power_fail_s, pin_n_s})
  );

  dvr_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // one sample leaving the block marks one sample period
  assign tick = out_valid && out_ready;

  always_comb begin
    st_d      = st_q;
    // either mute source gives the same soft mute request
    mute_req  = !pin_n_s || soft_mute_ctrl;
    emerg_req = clock_error || power_fail_s;
    // faults outrank a soft mute or unmute
    if (emerg_req) begin
      sel_src = SRC_EMERG;
    end else if (mute_req) begin
      sel_src = SRC_DOWN;
    end else begin
      sel_src = SRC_UP;
    end
    case (sel_src)
      SRC_EMERG: begin
        sel_iv   = st_q.emerg.iv;
        sel_step = st_q.emerg.step;
        goal     = '{left: DVR_VOL_MUTE, right: DVR_VOL_MUTE};
      end
      SRC_DOWN: begin
        sel_iv   = st_q.normal.down_iv;
        sel_step = st_q.normal.down_step;
        goal     = '{left: DVR_VOL_MUTE, right: DVR_VOL_MUTE};
      end
      default: begin
        sel_iv   = st_q.normal.up_iv;
        sel_step = st_q.normal.up_step;
        goal     = '{left: left_target_volume, right: right_target_volume};
      end
    endcase
    at_goal = (st_q.vol == goal);

    // settings source change restarts the interval count
    st_d.src = sel_src;
    if (sel_src != st_q.src) begin
      st_d.cnt = '0;
    end

    if (sel_iv == DVR_IV_INSTANT) begin
      st_d.vol = goal;
      st_d.cnt = '0;
    end else if (tick && (sel_src == st_q.src) && !at_goal) begin
      if (st_q.cnt >= dvr_last(sel_iv)) begin
        st_d.cnt = '0;
        // clamped step, stops at the goal
        st_d.vol.left  = dvr_toward(st_q.vol.left, goal.left,
                                    dvr_step(sel_step));
        st_d.vol.right = dvr_toward(st_q.vol.right, goal.right,
                                    dvr_step(sel_step));
      end else begin
        st_d.cnt = st_q.cnt + 2'h1;
      end
    end

    case (sel_src)
      SRC_EMERG: st_d.state = DVR_EMERG;
      SRC_DOWN:  st_d.state = (st_d.vol == goal) ? DVR_MUTED : DVR_DOWN;
      SRC_UP:    st_d.state = (st_d.vol == goal) ? DVR_PLAY : DVR_UP;
      default:   st_d.state = DVR_PLAY;
    endcase

    // register port; writes on a read cycle still land
    if (reg_req.wr) begin
      if (reg_req.addr == DVR_NORMAL_OFS) begin
        st_d.normal = dvr_normal_type'(reg_req.wdata);
      end
      if (reg_req.addr == DVR_EMERG_OFS) begin
        st_d.emerg = dvr_emerg_type'(reg_req.wdata);
      end
    end
    st_d.rvalid = reg_req.rd;
    if (reg_req.rd) begin
      case (reg_req.addr)
        DVR_NORMAL_OFS: st_d.rdata = st_q.normal;
        DVR_EMERG_OFS:  st_d.rdata = st_q.emerg;
        DVR_STATUS_OFS: st_d.rdata = {3'h0, emerg_req, mute_req,
                                      st_q.state};
        default:        st_d.rdata = DVR_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // start muted and let the up ramp bring in the target
      st_q <= '{state:  DVR_UP,
                src:    SRC_UP,
                cnt:    2'h0,
                vol:    '{left: DVR_VOL_MUTE, right: DVR_VOL_MUTE},
                normal: dvr_normal_type'(DVR_NORMAL_RST),
                emerg:  dvr_emerg_type'(DVR_EMERG_RST),
                rdata:  DVR_ZERO_BYTE,
                rvalid: 1'b0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign vol_out    = st_q.vol;
  assign ramp_state = st_q.state;
  assign reg_rdata  = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;

  // checks

  instant_mute_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sel_src == SRC_DOWN &&
     st_q.normal.down_iv == DVR_IV_INSTANT)
    |=> (st_q.vol.left == DVR_VOL_MUTE && st_q.vol.right == DVR_VOL_MUTE))
    else $error("instant mute did not reach mute code");

  instant_unmute_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sel_src == SRC_UP && st_q.normal.up_iv == DVR_IV_INSTANT)
    |=> (st_q.vol.left == $past(left_target_volume) &&
         st_q.vol.right == $past(right_target_volume)))
    else $error("instant unmute did not restore target");

  emerg_instant_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && emerg_req && st_q.emerg.iv == DVR_IV_INSTANT)
    |=> (st_q.vol.left == DVR_VOL_MUTE && st_q.vol.right == DVR_VOL_MUTE))
    else $error("emergency instant mute missed");

  down_step_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == SRC_DOWN && st_q.src == SRC_DOWN &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.left == dvr_toward($past(st_q.vol.left), DVR_VOL_MUTE,
                          dvr_step($past(st_q.normal.down_step)))))
    else $error("normal down step size wrong");

  up_step_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == SRC_UP && st_q.src == SRC_UP &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.right == dvr_toward($past(st_q.vol.right),
                           $past(right_target_volume),
                           dvr_step($past(st_q.normal.up_step)))))
    else $error("up step size wrong");

  emerg_step_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && emerg_req && st_q.src == SRC_EMERG &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.left == dvr_toward($past(st_q.vol.left), DVR_VOL_MUTE,
                          dvr_step($past(st_q.emerg.step)))))
    else $error("emergency step did not lower volume");

  interval_hold_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == st_q.src && sel_iv != DVR_IV_INSTANT &&
     st_q.cnt < dvr_last(sel_iv) && !at_goal)
    |=> ($stable(st_q.vol) && st_q.cnt == $past(st_q.cnt) + 2'h1))
    else $error("volume moved inside an update interval");

  no_overshoot_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sel_src == SRC_UP && st_q.src == SRC_UP &&
     st_q.vol.left >= left_target_volume)
    |=> (st_q.vol.left >= $past(left_target_volume)))
    else $error("up ramp passed the target");

  emerg_priority_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && clock_error) |=> (st_q.state == DVR_EMERG))
    else $error("clock error did not select emergency ramp");

  mute_source_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && soft_mute_ctrl && !emerg_req)
    |=> (st_q.state == DVR_DOWN || st_q.state == DVR_MUTED))
    else $error("control bit mute did not ramp down");

  // steps on the other channel (right for down and emergency, left for up) follow the same settings
  down_right_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == SRC_DOWN && st_q.src == SRC_DOWN &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.right == dvr_toward($past(st_q.vol.right), DVR_VOL_MUTE,
                           dvr_step($past(st_q.normal.down_step)))))
    else $error("normal down step wrong on right");

  up_left_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == SRC_UP && st_q.src == SRC_UP &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.left == dvr_toward($past(st_q.vol.left),
                          $past(left_target_volume),
                          dvr_step($past(st_q.normal.up_step)))))
    else $error("up step wrong on left");

  emerg_right_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && tick && sel_src == SRC_EMERG && st_q.src == SRC_EMERG &&
     sel_iv != DVR_IV_INSTANT && st_q.cnt >= dvr_last(sel_iv) && !at_goal)
    |=> (st_q.vol.right == dvr_toward($past(st_q.vol.right), DVR_VOL_MUTE,
                           dvr_step($past(st_q.emerg.step)))))
    else $error("emergency step wrong on right");

  // no sample period, no volume change except by an instant setting
  sample_gate_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && !tick && sel_iv != DVR_IV_INSTANT) |=> $stable(st_q.vol))
    else $error("volume moved without a sample period");

  emerg_source_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && power_fail_s) |=> (st_q.state == DVR_EMERG))
    else $error("power outage did not select emergency ramp");

  goal_hold_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && at_goal && sel_src != SRC_UP) |=> $stable(st_q.vol))
    else $error("volume left the mute goal");

  count_restart_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && sel_src != st_q.src) |=> (st_q.cnt == 2'h0))
    else $error("interval count not restarted");

  rvalid_pulse_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en |=> (reg_rvalid == $past(reg_req.rd)))
    else $error("read valid pulse wrong");

  normal_read_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && reg_req.rd && reg_req.addr == DVR_NORMAL_OFS)
    |=> (reg_rdata == $past(st_q.normal)))
    else $error("normal settings read back wrong");

  // a low enable must hold every bit of ramp state
  freeze_hold_a : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !clk_en |=> $stable(st_q))
    else $error("state moved with clock enable low");

endmodule : dvr_ramp

//--- src/dvr_pkg.sv
// constants, carriers and helpers of the digital volume ramp control
package dvr_pkg;

  // register map
  localparam logic [7:0] DVR_NORMAL_OFS = 8'h3f;
  localparam logic [7:0] DVR_EMERG_OFS  = 8'h40;
  localparam logic [7:0] DVR_STATUS_OFS = 8'hfe;

  // values after reset
  localparam logic [7:0] DVR_NORMAL_RST = 8'h11;
  localparam logic [7:0] DVR_EMERG_RST  = 8'h10;
  localparam logic [7:0] DVR_VOL_MUTE   = 8'hff;
  localparam logic [7:0] DVR_ZERO_BYTE  = 8'h00;

  // field positions of the normal ramp register
  localparam int DVR_DOWN_IV_POS   = 6;
  localparam int DVR_DOWN_STEP_POS = 4;
  localparam int DVR_UP_IV_POS     = 2;
  localparam int DVR_UP_STEP_POS   = 0;

  // interval codes and last count values in sample periods
  localparam logic [1:0] DVR_IV_ONE     = 2'h0;
  localparam logic [1:0] DVR_IV_TWO     = 2'h1;
  localparam logic [1:0] DVR_IV_FOUR    = 2'h2;
  localparam logic [1:0] DVR_IV_INSTANT = 2'h3;
  localparam logic [1:0] DVR_LAST_ONE   = 2'h0;
  localparam logic [1:0] DVR_LAST_TWO   = 2'h1;
  localparam logic [1:0] DVR_LAST_FOUR  = 2'h3;

  // step sizes in half-dB codes
  localparam logic [7:0] DVR_STEP_4DB  = 8'h08;
  localparam logic [7:0] DVR_STEP_2DB  = 8'h04;
  localparam logic [7:0] DVR_STEP_1DB  = 8'h02;
  localparam logic [7:0] DVR_STEP_HALF = 8'h01;

  // stream defaults
  localparam int DVR_SAMPLE_W   = 32;
  localparam int DVR_FIFO_DEPTH = 16;

  typedef struct packed {
    logic [1:0] down_iv;
    logic [1:0] down_step;
    logic [1:0] up_iv;
    logic [1:0] up_step;
  } dvr_normal_type;

  typedef struct packed {
    logic [1:0] iv;
    logic [1:0] step;
    logic [3:0] spare;
  } dvr_emerg_type;

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } dvr_vol_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dvr_reg_req_type;

  typedef enum logic [2:0] {
    DVR_PLAY,
    DVR_UP,
    DVR_DOWN,
    DVR_MUTED,
    DVR_EMERG
  } dvr_state_type;

  function automatic logic [7:0] dvr_step(input logic [1:0] code);
    case (code)
      2'h0:    dvr_step = DVR_STEP_4DB;
      2'h1:    dvr_step = DVR_STEP_2DB;
      2'h2:    dvr_step = DVR_STEP_1DB;
      default: dvr_step = DVR_STEP_HALF;
    endcase
  endfunction : dvr_step

  function automatic logic [1:0] dvr_last(input logic [1:0] code);
    case (code)
      DVR_IV_TWO:  dvr_last = DVR_LAST_TWO;
      DVR_IV_FOUR: dvr_last = DVR_LAST_FOUR;
      default:     dvr_last = DVR_LAST_ONE;
    endcase
  endfunction : dvr_last

  // one step from cur toward tgt, never past it
  function automatic logic [7:0] dvr_toward(input logic [7:0] cur,
                                            input logic [7:0] tgt,
                                            input logic [7:0] step);
    logic [8:0] sum;
    logic [8:0] dif;
    sum = {1'b0, cur} + {1'b0, step};
    dif = {1'b0, cur} - {1'b0, step};
    if (cur < tgt) begin
      dvr_toward = (sum > {1'b0, tgt}) ? tgt : sum[7:0];
    end else if (cur > tgt) begin
      dvr_toward = (dif[8] || (dif[7:0] < tgt)) ? tgt : dif[7:0];
    end else begin
      dvr_toward = cur;
    end
  endfunction : dvr_toward

endpackage : dvr_pkg

//--- src/dvr_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module dvr_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // signals
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } dvr_sync_st_type;

  dvr_sync_st_type st_q;
  dvr_sync_st_type st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // s1 feeds only s2; the filter looks at s2 and s3
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.stable[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, stable: INIT};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : dvr_sync

//--- src/dvr_fifo.sv
// sample fifo with registered read data
`timescale 1ns/1ps
module dvr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    ovalid;
    logic [W-1:0]            odata;
  } dvr_fifo_st_type;

  dvr_fifo_st_type st_q;
  dvr_fifo_st_type st_d;
  logic            push;
  logic            load;

  always_comb begin
    st_d = st_q;
    push = in_valid && !st_q.full;
    load = (!st_q.ovalid || out_ready) && (st_q.cnt != '0);
    if (st_q.ovalid && out_ready) begin
      st_d.ovalid = 1'b0;
    end
    if (push) begin
      st_d.mem[st_q.wptr] = in_data;
      st_d.wptr = (st_q.wptr == LAST_PTR) ? '0 : st_q.wptr + 1'b1;
    end
    if (load) begin
      // read port is a register: the head moves out one cycle later
      st_d.odata  = st_q.mem[st_q.rptr];
      st_d.ovalid = 1'b1;
      st_d.rptr   = (st_q.rptr == LAST_PTR) ? '0 : st_q.rptr + 1'b1;
    end
    st_d.cnt  = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(load);
    st_d.full = (st_d.cnt == FULL_CNT);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign in_ready  = !st_q.full;
  assign out_valid = st_q.ovalid;
  assign out_data  = st_q.odata;

endmodule : dvr_fifo

//--- testbench/dvr_ramp_tb.sv
// self-checking bench for the digital volume ramp controller
`timescale 1ns/1ps
module dvr_ramp_tb;
  import dvr_pkg::*;

  typedef struct {
    logic [7:0] cfg;
    logic [1:0] src;
    logic       up;
    logic [7:0] step;
    int         n;
  } dvr_row_type;

  localparam logic [7:0] TGT_L     = 8'h30;
  localparam logic [7:0] TGT_R     = 8'h41;
  localparam int         CYC_LIMIT = 40000;

  logic                    core_clk;
  logic                    sys_rst;
  logic                    clk_en;
  logic                    soft_mute_pin_n;
  logic                    soft_mute_ctrl;
  logic                    clock_error;
  logic                    power_fail;
  dvr_reg_req_type         reg_req;
  logic [7:0]              reg_rdata;
  logic                    reg_rvalid;
  logic                    in_valid;
  logic                    in_ready;
  logic [DVR_SAMPLE_W-1:0] in_data;
  logic                    out_valid;
  logic                    out_ready;
  logic [DVR_SAMPLE_W-1:0] out_data;
  dvr_vol_type             vol_out;
  dvr_state_type           ramp_state;
  int                      mismatches = 0;
  int                      cmp_count  = 0;
  int                      cyc        = 0;
  int                      tick_cnt   = 0;

  // cfg, source (ctrl, pin, clock error, power fail), up, step, interval
  // an interval of 0 means the instant jump
  dvr_row_type rows [15] = '{
    '{8'h00, 2'd0, 1'b0, 8'h08, 1},
    '{8'h50, 2'd1, 1'b0, 8'h04, 2},
    '{8'ha0, 2'd0, 1'b0, 8'h02, 4},
    '{8'hf0, 2'd1, 1'b0, 8'h00, 0},
    '{8'h30, 2'd1, 1'b0, 8'h01, 1},
    '{8'h00, 2'd1, 1'b1, 8'h08, 1},
    '{8'h05, 2'd0, 1'b1, 8'h04, 2},
    '{8'h0a, 2'd1, 1'b1, 8'h02, 4},
    '{8'h0f, 2'd0, 1'b1, 8'h00, 0},
    '{8'h03, 2'd0, 1'b1, 8'h01, 1},
    '{8'h00, 2'd2, 1'b0, 8'h08, 1},
    '{8'h50, 2'd3, 1'b0, 8'h04, 2},
    '{8'ha0, 2'd2, 1'b0, 8'h02, 4},
    '{8'hf0, 2'd3, 1'b0, 8'h00, 0},
    '{8'h30, 2'd2, 1'b0, 8'h01, 1}
  };

  dvr_ramp #(
    .SAMPLE_W  (DVR_SAMPLE_W),
    .FIFO_DEPTH(DVR_FIFO_DEPTH)
  ) dvr_ramp_i (
    .core_clk           (core_clk),
    .sys_rst            (sys_rst),
    .clk_en             (clk_en),
    .soft_mute_pin_n    (soft_mute_pin_n),
    .soft_mute_ctrl     (soft_mute_ctrl),
    .clock_error        (clock_error),
    .power_fail         (power_fail),
    .left_target_volume (TGT_L),
    .right_target_volume(TGT_R),
    .reg_req            (reg_req),
    .reg_rdata          (reg_rdata),
    .reg_rvalid         (reg_rvalid),
    .in_valid           (in_valid),
    .in_ready           (in_ready),
    .in_data            (in_data),
    .out_valid          (out_valid),
    .out_ready          (out_ready),
    .out_data           (out_data),
    .vol_out            (vol_out),
    .ramp_state         (ramp_state)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // sample periods are counted at the output handshake
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (out_valid === 1'b1 && out_ready === 1'b1) tick_cnt <= tick_cnt + 1;
    if (cyc == CYC_LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask : chk_cnt

  // inputs always move one nanosecond after the rising edge
  task automatic step_clk;
    @(posedge core_clk);
    #1;
  endtask : step_clk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step_clk();
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step_clk();
    reg_req = '0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    step_clk();
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step_clk();
    reg_req = '0;
    chk_val({7'h00, reg_rvalid}, 8'h01, "read strobe");
    chk_val(reg_rdata, exp, "read data");
  endtask : rd_chk

  task automatic set_src(input logic [1:0] s, input logic on);
    case (s)
      2'd0:    soft_mute_ctrl = on;
      2'd1:    soft_mute_pin_n = !on;
      2'd2:    clock_error = on;
      default: power_fail = on;
    endcase
  endtask : set_src

  task automatic wait_move(input logic [7:0] v);
    for (int i = 0; i < 600; i++) begin
      step_clk();
      if (vol_out.left !== v) break;
    end
  endtask : wait_move

  task automatic wait_vol(input logic [7:0] l, input logic [7:0] r);
    for (int i = 0; i < 3000; i++) begin
      step_clk();
      if (vol_out === {l, r}) break;
    end
    chk_val(vol_out.left, l, "left settles");
    chk_val(vol_out.right, r, "right settles");
  endtask : wait_vol

  // first update gives the step, first two updates give the spacing
  task automatic watch(input dvr_row_type r, input logic [7:0] goal,
                       input logic [2:0] mid);
    logic [7:0] v0;
    int         t1;
    v0 = vol_out.left;
    wait_move(v0);
    t1 = tick_cnt;
    if (r.n == 0) begin
      chk_val(vol_out.left, goal, "instant jump");
    end else begin
      v0 = r.up ? v0 - vol_out.left : vol_out.left - v0;
      chk_val(v0, r.step, "step size");
      chk_val({5'h00, ramp_state}, {5'h00, mid}, "ramp state");
      v0 = vol_out.left;
      wait_move(v0);
      chk_cnt(tick_cnt - t1, r.n, "interval");
    end
  endtask : watch

  initial begin
    dvr_row_type r;
    logic        rdy;
    logic [7:0]  gl;
    logic [7:0]  gr;
    int          n;
    int          e;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    soft_mute_pin_n = 1'b1;
    soft_mute_ctrl = 1'b0;
    clock_error = 1'b0;
    power_fail = 1'b0;
    reg_req = '0;
    in_valid = 1'b0;
    out_ready = 1'b0;
    in_data = '0;
    repeat (19) step_clk();
    chk_val(vol_out.left, 8'hff, "reset volume");
    chk_val({5'h00, ramp_state}, {5'h00, DVR_UP}, "reset state");
    chk_val({6'h00, in_ready, out_valid}, 8'h02, "reset stream");
    step_clk();
    sys_rst = 1'b0;
    $display("test reset done");

    // field reset values, spare bits writable, unmapped places inert
    rd_chk(DVR_NORMAL_OFS, 8'h11);
    rd_chk(DVR_EMERG_OFS, 8'h10);
    rd_chk(8'h55, 8'h00);
    wr_reg(DVR_EMERG_OFS, 8'ha5);
    wr_reg(8'h41, 8'h77);
    rd_chk(DVR_EMERG_OFS, 8'ha5);
    rd_chk(DVR_NORMAL_OFS, 8'h11);
    $display("test registers done");

    // fill with the drain stalled, then drain with a stalling reader
    in_valid = 1'b1;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk) rdy = in_ready;
      step_clk();
      if (rdy === 1'b1) begin
        n++;
        in_data = DVR_SAMPLE_W'(n);
      end
    end
    in_valid = 1'b0;
    chk_cnt(n, 17, "fifo capacity");
    e = 0;
    for (int i = 0; i < 80; i++) begin
      step_clk();
      out_ready = (i % 3 != 0);
      @(negedge core_clk);
      if (out_valid === 1'b1 && out_ready) begin
        chk_cnt(out_data, e, "fifo order");
        e++;
      end
    end
    chk_cnt(e, n, "fifo drained");
    $display("test fifo done");

    step_clk();
    in_valid = 1'b1;
    out_ready = 1'b1;
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      gl = r.up ? TGT_L : 8'hff;
      gr = r.up ? TGT_R : 8'hff;
      // reach the start point fast: instant settings on the other way
      set_src(r.src, r.up);
      wr_reg(DVR_NORMAL_OFS, r.up ? 8'hc0 : (r.src[1] ? 8'hff : 8'h0c));
      wait_vol(r.up ? 8'hff : TGT_L, r.up ? 8'hff : TGT_R);
      wr_reg(r.src[1] ? DVR_EMERG_OFS : DVR_NORMAL_OFS, r.cfg);
      set_src(r.src, !r.up);
      watch(r, gl, r.up ? DVR_UP : (r.src[1] ? DVR_EMERG : DVR_DOWN));
      wait_vol(gl, gr);
      chk_val({5'h00, ramp_state},
              {5'h00, r.up ? DVR_PLAY : (r.src[1] ? DVR_EMERG : DVR_MUTED)},
              "settled state");
      set_src(r.src, 1'b0);
      $display("test row %0d done", i);
    end

    // unmute in mid ramp turns the ramp round with the up settings
    wait_vol(TGT_L, TGT_R);
    wr_reg(DVR_NORMAL_OFS, 8'hb3);
    set_src(2'd0, 1'b1);
    step_clk();
    rd_chk(DVR_STATUS_OFS, 8'h0a);
    repeat (36) step_clk();
    set_src(2'd0, 1'b0);
    r = '{8'hb3, 2'd0, 1'b1, 8'h01, 1};
    watch(r, TGT_L, DVR_UP);
    wait_vol(TGT_L, TGT_R);
    rd_chk(DVR_STATUS_OFS, 8'h00);
    $display("test reversal done");

    // a low clock enable freezes a ramp in flight, then it resumes
    set_src(2'd0, 1'b1);
    repeat (20) step_clk();
    gl = vol_out.left;
    clk_en = 1'b0;
    repeat (9) step_clk();
    chk_val(vol_out.left, gl, "frozen volume");
    chk_val({5'h00, ramp_state}, {5'h00, DVR_DOWN}, "frozen state");
    clk_en = 1'b1;
    wait_move(gl);
    chk_val(vol_out.left, gl + DVR_STEP_HALF, "resumed step");
    $display("test freeze done");

    // reset in mid run brings back mute and the reset settings
    sys_rst = 1'b1;
    step_clk();
    sys_rst = 1'b0;
    chk_val(vol_out.left, DVR_VOL_MUTE, "mid reset volume");
    chk_val({6'h00, in_ready, out_valid}, 8'h02, "mid reset stream");
    rd_chk(DVR_NORMAL_OFS, DVR_NORMAL_RST);
    $display("test mid reset done");
    final_report();
  end
endmodule : dvr_ramp_tb
